// [fams_cpu_model.sv]
`timescale 1ns/100ps
module fams_cpu_model (
  input  wire logic        clk,          // System clock
  input  wire logic        flashRdAck,   // Read complete pulse
  output logic             flashRdReq,   // Flash read request
  output logic             halfWrEn,     // Half-word write strobe
  output logic             halfWrUpper,  // Upper half select
  output logic      [15:0] halfWrData    // Half-word data
);
  initial
  begin
    flashRdReq  = 1'b0;
    halfWrEn    = 1'b0;
    halfWrUpper = 1'b0;
    halfWrData  = 16'h0000;
  end
  // Cycles from the take edge until the ack shows
  task automatic flash_read(output int lat);
    @(posedge clk);
    flashRdReq <= 1'b1;
    @(posedge clk);
    flashRdReq <= 1'b0;
    lat = 0;
    #1;
    while (!flashRdAck && lat < 40)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask : flash_read
  // Halves back to back so the word gets its ECC
  task automatic write_word(input logic [31:0] d, input bit upOnly);
    @(posedge clk);
    halfWrEn    <= 1'b1;
    halfWrUpper <= upOnly;
    halfWrData  <= upOnly ? d[31:16] : d[15:0];
    if (!upOnly)
    begin
      @(posedge clk);
      halfWrUpper <= 1'b1;
      halfWrData  <= d[31:16];
    end
    @(posedge clk);
    halfWrEn   <= 1'b0;
    halfWrData <= ~halfWrData; // Released data never looks held
  endtask : write_word
endmodule : fams_cpu_model

// [fams_pkg.sv]
// Behaviour
// - Access size 01 is 16-bit programming, 10 is 32-bit read mode.
// - Reset loads access size 10, giving 32-bit read-only execution mode.
// - First read after an algorithm command is a discarded dummy read; no read is discarded here.
// - Each word is two half-writes; ECC is formed once both are present.
// - Base read wait field resets to 00; only 00 is permitted; 10 is still stored here and adds two waits.
// - Low bit of base read wait field is fixed by hardware.
// - Status bit 2 sets when a flash read needed ECC correction.
// - Writing zero clears the ECC-correction bit; one has no effect.
// - Status bit 1 reads one while flash hangs after a timing overrun.
// - Status bit 0 reads zero while an algorithm runs; writes refused.
// - Status bits 7 to 3 are reserved, read as zero here, ignore writes.
// - Odd slow-down code N adds N waits; 000 none; even codes prohibited.
// - Total read wait is the base field plus the slow-down count.
// - Slow-down waits apply to reads in read-only execution mode.
package fams_pkg;
  localparam int          ADDR_W             = 4;
  localparam logic [3:0]  OFF_ACCESS_SIZE    = 4'h0;
  localparam logic [3:0]  OFF_READ_WAIT      = 4'h4;
  localparam logic [3:0]  OFF_STATUS         = 4'h8;
  localparam logic [3:0]  OFF_SLOWDOWN       = 4'hC;
  localparam logic [1:0]  ASZ_PROG16         = 2'h1;
  localparam logic [1:0]  ASZ_ROM32          = 2'h2;
  localparam logic [1:0]  ASZ_RESET          = 2'h2;
  localparam logic [1:0]  RWT_RESET          = 2'h0;
  localparam logic [2:0]  SD_RESET           = 3'h0;
  localparam int          STAT_RDY_BIT       = 0;
  localparam int          STAT_HNG_BIT       = 1;
  localparam int          STAT_ERR_BIT       = 2;
  localparam logic [3:0]  WAIT_MAX           = 4'hA;
  typedef enum logic [1:0] {
    FAMS_IDLE = 2'b00,
    FAMS_WAIT = 2'b01,
    FAMS_DONE = 2'b11
  } fams_rd_state_t;
  // Wait count added by a slow-down code; prohibited codes add nothing
  function automatic logic [3:0] fams_sd_waits(input logic [2:0] code);
    if (code[0])
    begin
      fams_sd_waits = {1'b0, code};
    end
    else
    begin
      fams_sd_waits = 4'h0;
    end
  endfunction : fams_sd_waits
endpackage : fams_pkg

// [fams_rd_if.sv]
`timescale 1ns/100ps
interface fams_rd_if;
  logic       req;
  logic [3:0] waits;
  logic       busy;
  logic       done;
  modport ctrl (output req, output waits, input busy, input done);
  modport seq  (input req, input waits, output busy, output done);
endinterface : fams_rd_if

// [fams_rd_wait.sv]
`timescale 1ns/100ps
module fams_rd_wait (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Sync reset, active low
  input  wire logic clkEn,    // Freeze when low
  fams_rd_if.seq    rd        // Read timing handshake
);
  import fams_pkg::*;

  fams_rd_state_t state_r;
  logic [3:0]     cnt_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= FAMS_IDLE;
      cnt_r   <= 4'h0;
    end
    else if (clkEn)
    begin
      case (state_r)
        FAMS_IDLE:
        begin
          if (rd.req)
          begin
            cnt_r   <= rd.waits;
            state_r <= (rd.waits == 4'h0) ? FAMS_DONE : FAMS_WAIT;
          end
        end
        FAMS_WAIT:
        begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1)
          begin
            state_r <= FAMS_DONE;
          end
        end
        FAMS_DONE:
        begin
          state_r <= FAMS_IDLE;
        end
        default:
        begin
          state_r <= FAMS_IDLE;
        end
      endcase
    end
  end

  assign rd.busy = (state_r != FAMS_IDLE);
  assign rd.done = (state_r == FAMS_DONE);

  AST_WAIT_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && !rd.busy && rd.req && rd.waits == 4'h3) ##1 clkEn [*3]
    |=> rd.done)
    else $error("read wait length wrong");
endmodule : fams_rd_wait

// [fams_top.sv]
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module fams_top (
  input  wire logic                  clk,          // System clock
  input  wire logic                  rst_n,        // Sync reset, active low
  input  wire logic                  clkEn,        // Freeze when low
  input  wire logic [fams_pkg::ADDR_W-1:0] regAddr,      // Register address
  input  wire logic [31:0]           regWdata,     // Write data
  input  wire logic                  regWr,        // Write strobe
  input  wire logic                  regRd,        // Read strobe
  output logic      [31:0]           regRdata,     // Read data, next cycle
  input  wire logic                  flashRdReq,   // Flash array read request
  output logic                       flashRdAck,   // Read data valid pulse
  output logic                       flashRdBusy,  // Read in progress
  input  wire logic                  eccCorrected, // Read needed ECC fix
  input  wire logic                  algoBusy,     // Algorithm running
  input  wire logic                  timingLimitExceededFlag, // Overrun
  input  wire logic                  hangClear,    // Flash reset command seen
  input  wire logic                  halfWrEn,     // Half-word array write
  input  wire logic                  halfWrUpper,  // Write hits word upper half
  input  wire logic [15:0]           halfWrData,   // Half-word write data
  output logic      [31:0]           wordData,     // Assembled word for ECC
  output logic                       wordValid,    // Word ready, one pulse
  output logic                       wrRefused,    // Write dropped pulse
  output logic                       progMode,     // 16-bit programming mode
  output logic      [3:0]            totalWaits    // Waits applied to reads
);
  import fams_pkg::*;

  logic [1:0]  accessSizeField_r;
  logic [1:0]  baseReadWaitField_r;
  logic [2:0]  addedWaitField_r;
  logic        eccErr_r;
  logic        hangFlag_r;
  logic [15:0] lowHalf_r;
  logic        lowHave_r;
  logic [31:0] regRdata_r;
  logic        wrRefused_r;
  logic        wordValid_r;
  logic [31:0] wordData_r;
  logic        eccErr_nxt;
  logic        wrSize;
  logic        wrWait;
  logic        wrStat;
  logic        wrSd;
  logic        romMode;

  fams_rd_if rdIf ();

  fams_rd_wait uWait (
    .clk   (clk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .rd    (rdIf.seq)
  );

  assign wrSize  = regWr && (regAddr == OFF_ACCESS_SIZE);
  assign wrWait  = regWr && (regAddr == OFF_READ_WAIT);
  assign wrStat  = regWr && (regAddr == OFF_STATUS);
  assign wrSd    = regWr && (regAddr == OFF_SLOWDOWN);
  assign romMode = (accessSizeField_r == ASZ_ROM32);

  // Prohibited access size codes are kept; neither mode is then active
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      accessSizeField_r <= ASZ_RESET;
    end
    else if (clkEn && wrSize)
    begin
      accessSizeField_r <= regWdata[1:0];
    end
  end

  assign progMode = (accessSizeField_r == ASZ_PROG16);

  // Bit 0 stays at zero whatever is written
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      baseReadWaitField_r <= RWT_RESET;
    end
    else if (clkEn && wrWait)
    begin
      baseReadWaitField_r <= {regWdata[1], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addedWaitField_r <= SD_RESET;
    end
    else if (clkEn && wrSd)
    begin
      addedWaitField_r <= regWdata[2:0];
    end
  end

  // Waits only count in 32-bit read mode
  assign totalWaits = romMode ?
    ({2'b00, baseReadWaitField_r} + fams_sd_waits(addedWaitField_r)) :
    4'h0;

  assign rdIf.req    = flashRdReq && !rdIf.busy;
  assign rdIf.waits  = totalWaits;
  assign flashRdAck  = rdIf.done;
  assign flashRdBusy = rdIf.busy;

  // Set wins over a software clear in the same cycle
  always_comb
  begin
    eccErr_nxt = eccErr_r;
    if (wrStat && !regWdata[STAT_ERR_BIT])
    begin
      eccErr_nxt = 1'b0;
    end
    if (eccCorrected && flashRdAck)
    begin
      eccErr_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      eccErr_r <= 1'b0;
    end
    else if (clkEn)
    begin
      eccErr_r <= eccErr_nxt;
    end
  end

  // Hang holds until the reset command; an overrun the same cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hangFlag_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (timingLimitExceededFlag)
      begin
        hangFlag_r <= 1'b1;
      end
      else if (hangClear)
      begin
        hangFlag_r <= 1'b0;
      end
    end
  end

  // Half-word pairing; lower half first, upper half completes the word
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lowHalf_r   <= 16'h0000;
      lowHave_r   <= 1'b0;
      wordData_r  <= 32'h0000_0000;
      wordValid_r <= 1'b0;
      wrRefused_r <= 1'b0;
    end
    else if (clkEn)
    begin
      wordValid_r <= 1'b0;
      wrRefused_r <= 1'b0;
      if (halfWrEn)
      begin
        if (!progMode || algoBusy)
        begin
          wrRefused_r <= 1'b1;
        end
        else if (!halfWrUpper)
        begin
          lowHalf_r <= halfWrData;
          lowHave_r <= 1'b1;
        end
        else if (lowHave_r)
        begin
          wordData_r  <= {halfWrData, lowHalf_r};
          wordValid_r <= 1'b1;
          lowHave_r   <= 1'b0;
        end
        else
        begin
          wrRefused_r <= 1'b1;
        end
      end
    end
  end

  assign wordData  = wordData_r;
  assign wordValid = wordValid_r;
  assign wrRefused = wrRefused_r;

  // Unmapped addresses read as zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      regRdata_r <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      regRdata_r <= 32'h0000_0000;
      if (regRd)
      begin
        case (regAddr)
          OFF_ACCESS_SIZE: regRdata_r[1:0] <= accessSizeField_r;
          OFF_READ_WAIT:   regRdata_r[1:0] <= baseReadWaitField_r;
          OFF_STATUS:
          begin
            regRdata_r[STAT_ERR_BIT] <= eccErr_r;
            regRdata_r[STAT_HNG_BIT] <= hangFlag_r;
            regRdata_r[STAT_RDY_BIT] <= !algoBusy;
          end
          OFF_SLOWDOWN:    regRdata_r[2:0] <= addedWaitField_r;
          default:         regRdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign regRdata = regRdata_r;

  AST_RESET_ROM: assert property (
    @(posedge clk)
    !rst_n |=> (accessSizeField_r == ASZ_ROM32))
    else $error("access size not ROM after reset");

  AST_MODE_DECODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && regWr && regAddr == OFF_ACCESS_SIZE)
    |=> progMode == ($past(regWdata[1:0]) == 2'h1))
    else $error("programming mode decode wrong");

  AST_RWT_BIT0: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && wrWait) |=> baseReadWaitField_r == {$past(regWdata[1]), 1'b0})
    else $error("read wait bit 0 changed");

  AST_ERR_SET: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && eccCorrected && flashRdAck) |=> eccErr_r)
    else $error("ECC flag not set");

  AST_ERR_W1: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && wrStat && regWdata[STAT_ERR_BIT] && eccErr_r) |=> eccErr_r)
    else $error("ECC flag cleared by one");

  AST_HANG: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && timingLimitExceededFlag) |=> hangFlag_r)
    else $error("hang flag not set");

  AST_HANG_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && hangFlag_r && !hangClear) |=> hangFlag_r)
    else $error("hang flag dropped without reset command");

  AST_REFUSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && halfWrEn && algoBusy) |=> (wrRefused && !wordValid))
    else $error("write accepted while busy");

  AST_RSV_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && regRd && regAddr == OFF_STATUS) |=> regRdata[31:3] == '0)
    else $error("reserved status bits nonzero");

  AST_WAIT_SUM: assert property (
    @(posedge clk) disable iff (!rst_n)
    (romMode && addedWaitField_r == 3'h5 && baseReadWaitField_r == 2'h0)
    |-> totalWaits == 4'h5)
    else $error("wait sum wrong");

  AST_SD_EVEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (romMode && baseReadWaitField_r == 2'h0 && !addedWaitField_r[0])
    |-> totalWaits == 4'h0)
    else $error("even slow-down code added waits");

  AST_PROG_NOWAIT: assert property (
    @(posedge clk) disable iff (!rst_n)
    progMode |-> totalWaits == 4'h0)
    else $error("waits in programming mode");

  AST_PAIR: assert property (
    @(posedge clk) disable iff (!rst_n)
    wordValid |-> $past(halfWrUpper))
    else $error("word without upper half");

  AST_ACK_ONE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && flashRdAck) |=> !flashRdAck)
    else $error("read ack longer than one cycle");

  AST_RDATA_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clkEn && !regRd) |=> regRdata == 32'h0000_0000)
    else $error("read data without a read strobe");

  AST_FREEZE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !clkEn |=> $stable({accessSizeField_r, baseReadWaitField_r,
      addedWaitField_r, eccErr_r, hangFlag_r}))
    else $error("state moved while clock enable low");
endmodule : fams_top

// [tb_flash_access_mode_status.sv]
`timescale 1ns/100ps
module tb_flash_access_mode_status;
  logic        clk, rst_n, clkEn, regWr, regRd, flashRdReq, flashRdAck;
  logic        eccCorrected, algoBusy, tlFlag, hangClear, halfWrEn;
  logic        halfWrUpper, wordValid, wrRefused, progMode, rdD, rdBusy;
  logic [3:0]  regAddr, totalWaits;
  logic [31:0] regWdata, regRdata, wordData, rnd;
  logic [15:0] halfWrData;
  logic [31:0] expQ[$];
  logic [31:0] wordQ[$];
  int          error_cnt, num_checks, refCnt, lat, busyCnt;
  fams_top u_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .flashRdReq(flashRdReq), .flashRdAck(flashRdAck),
    .flashRdBusy(rdBusy), .eccCorrected(eccCorrected), .algoBusy(algoBusy),
    .timingLimitExceededFlag(tlFlag), .hangClear(hangClear),
    .halfWrEn(halfWrEn), .halfWrUpper(halfWrUpper), .halfWrData(halfWrData),
    .wordData(wordData), .wordValid(wordValid), .wrRefused(wrRefused),
    .progMode(progMode), .totalWaits(totalWaits));
  fams_cpu_model u_cpu (.clk(clk), .flashRdAck(flashRdAck),
    .flashRdReq(flashRdReq), .halfWrEn(halfWrEn),
    .halfWrUpper(halfWrUpper), .halfWrData(halfWrData));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : reg_rd
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Results are matched against the oldest note
  always @(posedge clk)
  begin
    if (rdD)
      chk(regRdata, expQ.pop_front());
    if (wordValid)
      chk(wordData, wordQ.pop_front());
    if (wrRefused)
      refCnt++;
    if (rdBusy)
      busyCnt++;
    rdD <= regRd;
  end
  initial
  begin
    #300000;
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    {rst_n, regWr, regRd, eccCorrected, algoBusy, tlFlag, hangClear} = '0;
    {regAddr, regWdata, rdD} = '0;
    clkEn = 1'b1;
    rnd = 32'hcf91;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(4'h0, 32'h0000_0002);
    reg_rd(4'h4, 32'h0000_0000);
    reg_rd(4'hC, 32'h0000_0000);
    reg_rd(4'h8, 32'h0000_0001);
    reg_rd(4'h1, 32'h0000_0000);
    // A write while frozen must leave the register untouched
    @(posedge clk);
    clkEn <= 1'b0;
    reg_wr(4'hC, 32'h0000_0005);
    @(posedge clk);
    clkEn <= 1'b1;
    reg_rd(4'hC, 32'h0000_0000);
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(4'hC, 32'(c));
      reg_rd(4'hC, 32'(c));
      busyCnt = 0;
      u_cpu.flash_read(lat);
      chk(32'(lat), (c % 2) ? 32'(c) : 32'h0000_0000);
      chk(32'(busyCnt), (c % 2) ? 32'(c) : 32'h0000_0000);
    end
    reg_wr(4'h4, 32'h0000_0003);
    reg_rd(4'h4, 32'h0000_0002);
    u_cpu.flash_read(lat);
    chk(32'(lat), 32'h0000_0009);
    reg_wr(4'h4, 32'h0000_0000);
    @(posedge clk);
    eccCorrected <= 1'b1;
    u_cpu.flash_read(lat);
    @(posedge clk);
    eccCorrected <= 1'b0;
    reg_rd(4'h8, 32'h0000_0005);
    reg_wr(4'h8, 32'h0000_00FF);
    reg_rd(4'h8, 32'h0000_0005);
    reg_wr(4'h8, 32'h0000_0000);
    reg_rd(4'h8, 32'h0000_0001);
    @(posedge clk);
    tlFlag <= 1'b1;
    @(posedge clk);
    tlFlag <= 1'b0;
    reg_rd(4'h8, 32'h0000_0003);
    @(posedge clk);
    hangClear <= 1'b1;
    @(posedge clk);
    hangClear <= 1'b0;
    reg_rd(4'h8, 32'h0000_0001);
    @(posedge clk);
    algoBusy <= 1'b1;
    reg_rd(4'h8, 32'h0000_0000);
    reg_rd(4'h8, 32'h0000_0000);
    reg_wr(4'h0, 32'h0000_0001);
    reg_rd(4'h0, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, progMode}, 32'h0000_0001);
    chk({28'h0, totalWaits}, 32'h0000_0000);
    rnd = lfsr(rnd);
    u_cpu.write_word(rnd, 1'b0);
    @(posedge clk);
    algoBusy <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      wordQ.push_back(rnd);
      u_cpu.write_word(rnd, 1'b0);
    end
    u_cpu.write_word(lfsr(rnd), 1'b1);
    reg_wr(4'h0, 32'h0000_0002);
    u_cpu.write_word(rnd, 1'b0);
    for (int c = 0; c < 4; c += 3)
    begin
      reg_wr(4'h0, 32'(c));
      @(negedge clk);
      chk({31'h0, progMode}, 32'h0000_0000);
    end
    reg_wr(4'h0, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk(32'(refCnt), 32'h0000_0005);
    chk(32'(expQ.size() + wordQ.size()), 32'h0000_0000);
    wrap_up;
  end
endmodule : tb_flash_access_mode_status
